// [rtl/asc_map.svh]
// Offsets, field positions, reset values and counts of the serial control
// Summary of operation
// RULE1: Works with clock idling low or high
// RULE2: Host masters clock, polarity equals phase
// RULE3: Host clock at most 10MHz, 40-60% duty; the bench host runs it at 12.5MHz (HALF = 40 ns)
// RULE4: Serial port active only while select low
// RULE5: Output floats whenever select is high
// RULE6: Input sampled on each rising clock edge
// RULE7: Output bit changes on each falling edge
// RULE8: Select falling starts a new command
// RULE9: Each frame opens with MSB-first command byte
// RULE10: Byte after setup loads unipolar/bipolar register
// RULE11: Clock mode is setup bits 5 and 4
// RULE12: Mode 00: start pin launches whole sequence
// RULE13: Mode 01: each start pulse, one channel
// RULE14: Mode 10 default; conversion write starts work
// RULE15: Mode 11: host clock times acquisitions
// RULE16: Mode 11 disables scanning and averaging
// RULE17: Modes 00/10: flag low after last operation
// RULE18: Mode 01: flag low after each operation
// RULE19: Flag high when select or start falls
// RULE20: Mode 11 holds flag high always
// RULE21: Host trusts results only after flag low
// RULE22: Bipolar and temperature two's complement, else binary
// RULE23: Oldest result shifted out MSB first
// RULE24: Empty result store shifts out zeros
// RULE25: Start pin triggers only in modes 00/01
// RULE26: Select high clears partial byte and counter
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
// ************************************************
// Command byte decode, setup fields
// ************************************************
`define ASC_CMD_CONV   7
`define ASC_CMD_SETUP  6
`define ASC_CMD_AVG    5
`define ASC_CMD_FLUSH  4
`define ASC_CKM_HI     5
`define ASC_CKM_LO     4
`define ASC_SEL_UNI    2'h2
`define ASC_SEL_BIP    2'h3
`define ASC_SETUP_RST  8'h20
`define ASC_REG_RST    8'h00
// ************************************************
// Clock modes
// ************************************************
`define ASC_MODE_PSCAN 2'h0
`define ASC_MODE_PONE  2'h1
`define ASC_MODE_REG   2'h2
`define ASC_MODE_EXT   2'h3
// ************************************************
// Synchroniser lanes, result format, depth
// ************************************************
`define ASC_SY_CS      0
`define ASC_SY_ST      1
`define ASC_SY_BT      2
`define ASC_SY_PT      3
`define ASC_SYNC_RST   4'h3
`define ASC_LEAD       4'h0
`define ASC_SIGN_FLIP  10'h200
`define ASC_FIFO_DEPTH 16
`define ASC_LAST_BIT   3'h7
`define ASC_TOP_BIT    4'hf
`endif

// [rtl/asc_pkg.sv]
// Types shared by the serial control logic
`include "asc_map.svh"
package asc_pkg;
  // Decoder expectation for the next byte
  typedef enum logic [1:0] {
    ASC_DEC_CMD = 2'b00,
    ASC_DEC_UNI = 2'b01,
    ASC_DEC_BIP = 2'b10
  } asc_dec_type;
  // Register image seen by the converter core
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] uni;
    logic [7:0] bip;
    logic [7:0] conv;
    logic [7:0] avg;
  } asc_cfg_type;
  // Result from the converter core
  typedef struct packed {
    logic       valid;
    logic [9:0] code;
    logic [1:0] sub;
    logic       signd;
    logic       done;
  } asc_res_type;
  // Requests to the converter core
  typedef struct packed {
    logic req;
    logic scan;
    logic ext;
    logic scan_en;
    logic avg_en;
  } asc_cnv_type;
  // Main clock state
  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  lv;
    asc_dec_type dec;
    asc_cfg_type cfg;
    asc_cnv_type cnv;
    logic        eoc_n;
    logic        oe;
    logic [16:0] tx;
  } asc_ref_type;
  // Frame state on the serial clock
  typedef struct packed {
    logic [3:0] cnt;
    logic [6:0] sh;
  } asc_rx_type;
  // Persistent link state on the serial clock
  typedef struct packed {
    logic [7:0]  byte_v;
    logic        btg;
    logic [15:0] word;
    logic        ptg;
  } asc_lk_type;
endpackage

// [rtl/asc_top.sv]
// Serial port and conversion control of the converter
`timescale 1ns/1ps
`include "asc_map.svh"
module asc_top
  import asc_pkg::*;
#(
  parameter int DEPTH = `ASC_FIFO_DEPTH  // Result store entries
) (
  input  wire logic        ref_clk,      // Main clock
  input  wire logic        rst_b,        // Async reset, low
  input  wire logic        spi_sclk,     // Host serial clock
  input  wire logic        spi_cs_n,     // Chip select, low
  input  wire logic        spi_mosi,     // Serial data in
  output logic             spi_miso,     // Serial data out
  output logic             spi_miso_oe,  // Drive enable
  input  wire logic        conv_start_n, // Start pin, low
  output logic             eoc_n,        // End of conversion
  output logic             clock_mode_sel_hi,
  output logic             clock_mode_sel_lo,
  output asc_cfg_type      cfg,          // Register image
  output asc_cnv_type      cnv,          // Core requests
  input  asc_res_type      res           // Core results
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  // ************************************************
  // Main clock state
  // ************************************************
  asc_ref_type      r_q;                // Registered state
  asc_ref_type      r_d;                // Next state
  logic [15:0]      mem [DEPTH];        // Result store
  logic [AW-1:0]    wr_q;               // Write pointer
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;               // Read pointer
  logic [AW-1:0]    rd_d;
  logic [AW:0]      n_q;                // Entries held
  logic [AW:0]      n_d;
  logic [15:0]      wword;              // Formatted result
  logic             csf;                // Select fell
  logic             stf;                // Start pin fell
  logic             bev;                // Byte arrived
  logic             pev;                // Word taken
  logic [1:0]       mode;               // Clock mode
  logic             wr_cmd;             // Conversion write

  // ************************************************
  // Serial clock state
  // ************************************************
  asc_rx_type       x_q;                // Frame state
  asc_rx_type       x_d;
  asc_lk_type       k_q;                // Persistent state
  asc_lk_type       k_d;
  logic             miso_q;             // Output bit
  logic             link_rst_b;         // Frame reset

  // Frame logic resets while deselected
  assign link_rst_b = rst_b & ~spi_cs_n; // [RULE4] [RULE26]

  // Bit counter and input shifter
  always_comb begin
    x_d     = x_q;
    x_d.cnt = x_q.cnt + 4'h1;
    x_d.sh  = {x_q.sh[5:0], spi_mosi}; // [RULE6] [RULE9]
  end

  // Rising edge, frame part
  always_ff @(posedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      x_q <= '0;
    end else begin
      x_q <= x_d;
    end
  end

  // Byte hand-off and word capture
  always_comb begin
    k_d = k_q;
    if (!spi_cs_n) begin
      // Full byte: hold it and toggle
      if (x_q.cnt[2:0] == `ASC_LAST_BIT) begin
        k_d.byte_v = {x_q.sh, spi_mosi}; // [RULE9]
        k_d.btg    = ~k_q.btg;
      end
      // First rise of a word: copy head
      if (x_q.cnt == 4'h0) begin
        k_d.word = r_q.tx[15:0]; // [RULE23]
        if (r_q.tx[16]) begin
          k_d.ptg = ~k_q.ptg;
        end
      end
    end
  end

  // Rising edge, persistent part
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      k_q <= '0;
    end else begin
      k_q <= k_d;
    end
  end

  // Falling edge drives the next bit
  always_ff @(negedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= k_q.word[`ASC_TOP_BIT - x_q.cnt]; // [RULE7] [RULE1]
    end
  end

  // ************************************************
  // Main clock decode and control
  // ************************************************
  always_comb begin
    r_d      = r_q;
    wr_d     = wr_q;
    rd_d     = rd_q;
    n_d      = n_q;
    wr_cmd   = 1'b0;
    // Three-stage synchronisers
    r_d.s1 = {k_q.ptg, k_q.btg, conv_start_n, spi_cs_n};
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < 4; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.lv[i] = r_q.s3[i];
      end
    end
    csf  = r_q.lv[`ASC_SY_CS] & ~r_d.lv[`ASC_SY_CS];
    stf  = r_q.lv[`ASC_SY_ST] & ~r_d.lv[`ASC_SY_ST];
    bev  = r_q.lv[`ASC_SY_BT] ^ r_d.lv[`ASC_SY_BT];
    pev  = r_q.lv[`ASC_SY_PT] ^ r_d.lv[`ASC_SY_PT];
    mode = r_q.cfg.setup[`ASC_CKM_HI:`ASC_CKM_LO]; // [RULE11]
    r_d.cnv.req = 1'b0;
    // New frame expects a command byte
    if (csf) begin
      r_d.dec = ASC_DEC_CMD; // [RULE8]
    end
    // Byte decode
    if (bev) begin
      case (r_q.dec)
        ASC_DEC_UNI: begin
          r_d.cfg.uni = k_q.byte_v; // [RULE10]
          r_d.dec     = ASC_DEC_CMD;
        end
        ASC_DEC_BIP: begin
          r_d.cfg.bip = k_q.byte_v; // [RULE10]
          r_d.dec     = ASC_DEC_CMD;
        end
        default: begin
          if (k_q.byte_v[`ASC_CMD_CONV]) begin
            r_d.cfg.conv = k_q.byte_v;
            wr_cmd       = 1'b1;
          end else if (k_q.byte_v[`ASC_CMD_SETUP]) begin
            r_d.cfg.setup = k_q.byte_v;
            // Setup bits 1:0 select the second byte's target
            if (k_q.byte_v[1:0] == `ASC_SEL_UNI) begin
              r_d.dec = ASC_DEC_UNI; // [RULE10]
            end else if (k_q.byte_v[1:0] == `ASC_SEL_BIP) begin
              r_d.dec = ASC_DEC_BIP; // [RULE10]
            end
          end else if (k_q.byte_v[`ASC_CMD_AVG]) begin
            r_d.cfg.avg = k_q.byte_v;
          end else if (k_q.byte_v[`ASC_CMD_FLUSH]) begin
            rd_d = wr_q;
            n_d  = '0;
          end
        end
      endcase
    end
    // Conversion write starts work in modes 10 and 11
    if (wr_cmd && mode[1]) begin
      r_d.cnv.req  = 1'b1; // [RULE14] [RULE25]
      r_d.cnv.scan = ~mode[0];
      r_d.cnv.ext  = mode[0]; // [RULE15]
    end
    // Start pin acts in modes 00 and 01 only
    if (stf && !mode[1]) begin
      r_d.cnv.req  = 1'b1; // [RULE12] [RULE25]
      r_d.cnv.scan = ~mode[0]; // [RULE13]
      r_d.cnv.ext  = 1'b0;
    end
    // Mode 11 forbids scanning and averaging
    r_d.cnv.scan_en =
      (r_d.cfg.setup[`ASC_CKM_HI:`ASC_CKM_LO] != `ASC_MODE_EXT); // [RULE16]
    r_d.cnv.avg_en  = r_d.cnv.scan_en; // [RULE16]
    // End-of-conversion flag
    if (!r_d.cnv.scan_en) begin
      r_d.eoc_n = 1'b1; // [RULE20]
    end else if (res.done) begin
      r_d.eoc_n = 1'b0; // [RULE17] [RULE18]
    end else if (csf || stf) begin
      r_d.eoc_n = 1'b1; // [RULE19]
    end
    // Output enable follows the select
    r_d.oe = ~r_d.lv[`ASC_SY_CS]; // [RULE5]
    // Result format: leading zeros, code, sub-bits
    wword = {`ASC_LEAD,
             res.code ^ (res.signd ? `ASC_SIGN_FLIP : 10'h000),
             res.sub}; // [RULE22] [RULE23]
    // Word taken by the link
    if (pev && (n_d != '0)) begin
      rd_d = rd_d + 1'b1;
      n_d  = n_d - 1'b1;
    end
    // New result, oldest dropped when full
    if (res.valid) begin
      wr_d = wr_q + 1'b1;
      if (n_d == FULL) begin
        rd_d = rd_d + 1'b1;
      end else begin
        n_d = n_d + 1'b1;
      end
    end
    // Head for the link, zero when empty
    r_d.tx = (n_q != '0) ? {1'b1, mem[rd_q]} : 17'h00000; // [RULE24]
  end

  // Main clock registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q           <= '0;
      r_q.s1        <= `ASC_SYNC_RST;
      r_q.s2        <= `ASC_SYNC_RST;
      r_q.s3        <= `ASC_SYNC_RST;
      r_q.lv        <= `ASC_SYNC_RST;
      r_q.cfg.setup <= `ASC_SETUP_RST; // [RULE14]
      r_q.cnv.scan_en <= 1'b1;
      r_q.cnv.avg_en  <= 1'b1;
      r_q.eoc_n     <= 1'b1;
      wr_q          <= '0;
      rd_q          <= '0;
      n_q           <= '0;
    end else begin
      r_q  <= r_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      n_q  <= n_d;
    end
  end

  // Result store, no reset needed
  always_ff @(posedge ref_clk) begin
    if (res.valid) begin
      mem[wr_q] <= wword;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign spi_miso          = miso_q;
  assign spi_miso_oe       = r_q.oe;
  assign eoc_n             = r_q.eoc_n;
  assign cfg               = r_q.cfg;
  assign cnv               = r_q.cnv;
  assign clock_mode_sel_hi = r_q.cfg.setup[`ASC_CKM_HI];
  assign clock_mode_sel_lo = r_q.cfg.setup[`ASC_CKM_LO];

  // ************************************************
  // Assertions
  // ************************************************
  eoc_mode_ext_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE20]
    !r_q.cnv.scan_en |-> r_q.eoc_n)
    else $error("flag low in mode 11");
  eoc_done_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE17]
    (res.done && r_d.cnv.scan_en) |=> !eoc_n)
    else $error("flag not low after done");
  eoc_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE19]
    (csf && !res.done) |=> eoc_n)
    else $error("flag not high after select");
  ext_noscan_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE16]
    (mode == `ASC_MODE_EXT) |-> (!cnv.scan_en && !cnv.avg_en))
    else $error("scan left on in mode 11");
  pin_scan_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE12]
    (stf && mode == `ASC_MODE_PSCAN) |=> (cnv.req && cnv.scan))
    else $error("pin did not start scan");
  pin_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE13]
    (stf && mode == `ASC_MODE_PONE) |=> (cnv.req && !cnv.scan))
    else $error("pin did not start single");
  pin_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE25]
    (stf && mode[1] && !wr_cmd) |=> !cnv.req)
    else $error("pin acted in modes 10/11");
  reg_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE14]
    (wr_cmd && mode == `ASC_MODE_REG) |=> (cnv.req && cnv.scan && !cnv.ext))
    else $error("write did not start");
  oe_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE5]
    $rose(r_q.lv[`ASC_SY_CS]) |=> !spi_miso_oe)
    else $error("output driven while deselected");
  empty_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE24]
    (n_q == '0) |=> (r_q.tx == 17'h00000))
    else $error("empty store not zero");
  byte_hand_a: assert property (@(posedge spi_sclk) disable iff (!link_rst_b) // [RULE9]
    (x_q.cnt[2:0] == `ASC_LAST_BIT) |=> (k_q.btg != $past(k_q.btg)))
    else $error("byte not handed off");
  cover_reg_c:  cover property (@(posedge ref_clk) disable iff (!rst_b)
    wr_cmd && mode == `ASC_MODE_REG ##1 cnv.req);
  cover_pin_c:  cover property (@(posedge ref_clk) disable iff (!rst_b)
    stf && mode == `ASC_MODE_PSCAN ##1 cnv.req);
  cover_pop_c:  cover property (@(posedge ref_clk) disable iff (!rst_b)
    pev && n_q != '0);
endmodule

// [tb/asc_host.sv]
// Host model that masters the serial link of the converter
`timescale 1ns/1ps
module asc_host #(
  parameter int HALF = 40  // Half period of the serial clock, ns
) (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  // ************************************************
  // Line as the host sees it
  // ************************************************
  wire miso_w;  // Undriven line shows the inverse of mosi, never a held value
  assign miso_w = spi_miso_oe ? spi_miso : ~spi_mosi;

  // Idle levels at time zero
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // ************************************************
  // One select-framed transfer, clock still outside it
  // ************************************************
  task automatic frame(input int n, input logic cpol, input logic [47:0] tx,
                       output logic [47:0] rx);
    rx = '0;
    spi_sclk = cpol;            // Idle level, polarity equals phase
    #(HALF);
    spi_cs_n = 1'b0;            // Falling select opens a transaction
    #(HALF);
    for (int i = 0; i < n; i++) begin
      if (cpol) spi_sclk = 1'b0;
      spi_mosi = tx[47-i];      // Most significant bit first
      #(HALF) spi_sclk = 1'b1;  // Even duty cycle
      rx[47-i] = miso_w;        // Sampled on the rising edge
      #(HALF) if (!cpol) spi_sclk = 1'b0;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;       // Released data line changes
    #(HALF);
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the serial control block
`timescale 1ns/1ps
module tb_top
  import asc_pkg::*;
;
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
  // ************************************************
  // Signals
  // ************************************************
  localparam int          LIMIT = 60000;  // Cycle ceiling of the run
  localparam logic [47:0] WORDS = {4'h0, 10'h2a5, 2'h1, 4'h0, 10'h355, 2'h2, 16'h0};
  logic        ref_clk = 1'b0;
  logic        rst_b;
  logic        conv_start_n;
  wire         spi_sclk;
  wire         spi_cs_n;
  wire         spi_mosi;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic        eoc_n;
  logic        clock_mode_sel_hi;
  logic        clock_mode_sel_lo;
  asc_cfg_type cfg;
  asc_cnv_type cnv;
  asc_cnv_type last_cnv;    // Core request seen at the last pulse
  asc_res_type res;
  logic [47:0] rx;
  logic [1:0]  m;
  int          errors = 0;
  int          n_tests = 0;
  int          n_req = 0;   // Request pulses seen
  int          cyc = 0;
  int          base;
  wire  [1:0]  mode_w = {clock_mode_sel_hi, clock_mode_sel_lo};

  always #4 ref_clk = ~ref_clk;

  asc_top #(.DEPTH(16)) u_asc_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .conv_start_n(conv_start_n), .eoc_n(eoc_n), .clock_mode_sel_hi(clock_mode_sel_hi),
    .clock_mode_sel_lo(clock_mode_sel_lo), .cfg(cfg), .cnv(cnv), .res(res));

  asc_host u_asc_host (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  // ************************************************
  // Tasks
  // ************************************************
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic send8(input logic [7:0] b);
    u_asc_host.frame(8, 1'b0, {b, 40'h0}, rx);
    tick(10);
  endtask
  task automatic send16(input logic [15:0] w);
    u_asc_host.frame(16, 1'b0, {w, 32'h0}, rx);
    tick(10);
  endtask
  task automatic start_pulse();
    conv_start_n <= 1'b0;
    tick(4);
    conv_start_n <= 1'b1;
    tick(10);
  endtask
  task automatic done_pulse();
    res.done <= 1'b1;
    tick(1);
    res.done <= 1'b0;
    tick(4);
  endtask
  task automatic push(input logic [9:0] code, input logic [1:0] sub, input logic sgn);
    res <= '{valid: 1'b1, code: code, sub: sub, signd: sgn, done: 1'b0};
    tick(1);
    res.valid <= 1'b0;
    tick(2);
  endtask

  // Request monitor and hang guard, sampled away from the launch edge
  always @(negedge ref_clk) begin
    cyc <= cyc + 1;
    if (cnv.req === 1'b1) begin
      n_req <= n_req + 1;
      last_cnv <= cnv;
    end
    if (cyc == LIMIT) begin
      errors++;
      tally_and_finish();
    end
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    rst_b = 1'b0;
    conv_start_n = 1'b1;
    res = '0;
    tick(6);
    rst_b <= 1'b1;
    tick(3);
    `CHK("setup", 8'h20, cfg.setup)
    `CHK("mode", 2'h2, mode_w)
    `CHK("oe", 1'b0, spi_miso_oe)
    // Two results read in both polarities, then an empty store
    for (int p = 0; p < 2; p++) begin
      push(10'h2a5, 2'h1, 1'b0);
      push(10'h155, 2'h2, 1'b1);
      u_asc_host.frame(48, p[0], 48'h0, rx);
      tick(10);
      `CHK("words", WORDS, rx)
      `CHK("oe idle", 1'b0, spi_miso_oe)
    end
    // Every clock mode: flag, start pin and conversion write
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      send8({2'b01, m, 4'h0});
      `CHK("mode", m, mode_w)
      `CHK("eoc cs", 1'b1, eoc_n)
      done_pulse();
      `CHK("eoc done", m == 2'h3, eoc_n)
      base = n_req;
      start_pulse();
      `CHK("eoc start", 1'b1, eoc_n)
      `CHK("start req", int'(m < 2'h2), n_req - base)
      if (m < 2'h2) begin
        `CHK("scan", m == 2'h0, last_cnv.scan)
      end
      base = n_req;
      send8(8'h81);
      `CHK("conv", 8'h81, cfg.conv)
      `CHK("conv req", int'(m >= 2'h2), n_req - base)
      if (m >= 2'h2) begin
        `CHK("ext", m == 2'h3, last_cnv.ext)
      end
      `CHK("scan_en", m != 2'h3, cnv.scan_en)
      `CHK("avg_en", m != 2'h3, cnv.avg_en)
    end
    // Second byte after setup loads unipolar, then bipolar
    send16({8'h62, 8'ha5});
    `CHK("setup", 8'h62, cfg.setup)
    `CHK("uni", 8'ha5, cfg.uni)
    send16({8'h63, 8'h3c});
    `CHK("bip", 8'h3c, cfg.bip)
    // Partial byte dropped when select rises
    u_asc_host.frame(3, 1'b0, {3'h7, 45'h0}, rx);
    tick(10);
    base = n_req;
    send8(8'h40);
    `CHK("aligned", 8'h40, cfg.setup)
    `CHK("stray req", 0, n_req - base)
    // Averaging write, then a flush empties the store
    send8(8'h25);
    `CHK("avg", 8'h25, cfg.avg)
    push(10'h0f0, 2'h3, 1'b0);
    push(10'h10f, 2'h1, 1'b0);
    send8(8'h10);
    u_asc_host.frame(16, 1'b0, 48'h0, rx);
    tick(10);
    `CHK("flushed", 48'h0, rx)
    tally_and_finish();
  end
endmodule
